// file: rtl/ppwm_measure.v
`timescale 1ns/10ps
`include "ppwm_map.vh"
module ppwm_measure #(
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Control
   input wire countStart,
   input wire [1:0] srcSel,
   input wire measMode,
   input wire subTick,
   input wire modeRegWrite,
   input wire timerWrite,
   input wire [CNT_W-1:0] timerWrData,
   // Measurement input
   input wire measurementPulsePin,
   // Status and result
   output reg [CNT_W-1:0] timerRdData,
   output reg resultValid,
   output reg overflowFlag,
   output reg irqReq
);
   ////////////////////////////////////////////////////////////////////////////
   // Measurement phase codes, one-hot
   localparam [2:0] PH_WAIT1 = 3'h1;
   localparam [2:0] PH_WAIT2 = 3'h2;
   localparam [2:0] PH_VALID = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and next values
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;
   reg [CNT_W-1:0] reload_q;
   reg [CNT_W-1:0] reload_d;
   reg pin_q;
   reg [1:0] srcLatch_q;
   reg [1:0] srcLatch_d;
   reg [2:0] phase_q;
   reg [2:0] phase_d;
   reg ovf_q;
   reg ovf_d;
   reg irq_d;
   reg valid_d;

   ////////////////////////////////////////////////////////////////////////////
   // Combinational nets
   wire tick;
   wire effEdge;
   wire firstEdge;
   wire cntAtMax;
   wire ovfEvent;
   wire ovfClear;
   wire [1:0] srcUse;
   wire [CNT_W-1:0] cntOne;
   wire [CNT_W-1:0] cntInc;

   ////////////////////////////////////////////////////////////////////////////
   // Edge decode for a given measurement mode
   function edgeHit;
      input mode;
      input prevLevel;
      input curLevel;
      begin
         if (mode == `PPWM_MODE_WIDTH) begin
            edgeHit = prevLevel ^ curLevel;
         end else begin
            edgeHit = prevLevel & ~curLevel;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Source lock while counting
   assign srcUse = countStart ? srcLatch_q : srcSel;
   always @* begin
      srcLatch_d = srcLatch_q;
      if (!countStart) begin
         srcLatch_d = srcSel;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         srcLatch_q <= `PPWM_SRC_DIV1;
      end else begin
         srcLatch_q <= srcLatch_d;
      end
   end
   ppwm_prescaler uPre (
      .clk(clk),
      .srst(srst),
      .srcSel(srcUse),
      .subTick(subTick),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection; pin history idles high so reset gives no false fall
   always @(posedge clk) begin
      if (srst) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= measurementPulsePin;
      end
   end
   assign effEdge = countStart & edgeHit(measMode, pin_q, measurementPulsePin);

   ////////////////////////////////////////////////////////////////////////////
   // Overflow detect; an effective edge takes precedence over the tick
   assign cntAtMax = &cnt_q;
   assign ovfEvent = countStart & ~effEdge & tick & cntAtMax;
   assign ovfClear = modeRegWrite & countStart;

   ////////////////////////////////////////////////////////////////////////////
   // Counter and reload; timer writes have no path here
   assign cntOne = {{(CNT_W-1){1'b0}}, 1'b1};
   assign cntInc = cnt_q + cntOne;
   always @* begin
      cnt_d = cnt_q;
      reload_d = reload_q;
      if (countStart) begin
         if (effEdge) begin
            reload_d = cnt_q;
            cnt_d = `PPWM_CNT_RST;
         end else if (tick) begin
            cnt_d = cntInc;
         end
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         cnt_q <= `PPWM_CNT_RST;
         reload_q <= `PPWM_RELOAD_RST;
      end else begin
         cnt_q <= cnt_d;
         reload_q <= reload_d;
      end
   end
   // timerWrite and timerWrData are deliberately unused

   ////////////////////////////////////////////////////////////////////////////
   // Measurement phase since start
   always @* begin
      if (!countStart) begin
         phase_d = PH_WAIT1;
      end else begin
         case (phase_q)
            PH_WAIT1: begin
               if (effEdge) begin
                  phase_d = PH_WAIT2;
               end else begin
                  phase_d = PH_WAIT1;
               end
            end
            PH_WAIT2: begin
               if (effEdge) begin
                  phase_d = PH_VALID;
               end else begin
                  phase_d = PH_WAIT2;
               end
            end
            PH_VALID: begin
               phase_d = PH_VALID;
            end
            default: begin
               phase_d = PH_WAIT1;
            end
         endcase
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         phase_q <= PH_WAIT1;
      end else begin
         phase_q <= phase_d;
      end
   end
   assign firstEdge = effEdge & (phase_q == PH_WAIT1);

   ////////////////////////////////////////////////////////////////////////////
   // Next values of the status outputs
   always @* begin
      valid_d = 1'b0;
      if (countStart) begin
         if (phase_q == PH_VALID) begin
            valid_d = 1'b1;
         end else if (phase_q == PH_WAIT2 && effEdge) begin
            valid_d = 1'b1;
         end
      end
   end
   always @* begin
      irq_d = (effEdge & ~firstEdge) | ovfEvent;
   end
   always @* begin
      ovf_d = ovf_q;
      if (ovfEvent) begin
         ovf_d = 1'b1;
      end else if (ovfClear) begin
         ovf_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output registers
   always @(posedge clk) begin
      if (srst) begin
         timerRdData <= `PPWM_RELOAD_RST;
      end else begin
         timerRdData <= reload_d;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         resultValid <= 1'b0;
      end else begin
         resultValid <= valid_d;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= irq_d;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= ovf_d;
      end
   end
   always @* begin
      overflowFlag = ovf_q;
   end
endmodule // ppwm_measure

// file: rtl/ppwm_map.vh
`ifndef PPWM_MAP_VH
`define PPWM_MAP_VH
// Count source select codes
`define PPWM_SRC_DIV1 2'h0
`define PPWM_SRC_DIV8 2'h1
`define PPWM_SRC_DIV32 2'h2
`define PPWM_SRC_SUB 2'h3
// Prescaler ratios
`define PPWM_DIV8_LAST 5'h07
`define PPWM_DIV32_LAST 5'h1F
// Measurement mode select
`define PPWM_MODE_PERIOD 1'b0
`define PPWM_MODE_WIDTH 1'b1
// Reset values and counter maximum
`define PPWM_CNT_RST 16'h0000
`define PPWM_RELOAD_RST 16'h0000
`define PPWM_CNT_MAX 16'hFFFF
`endif

// file: rtl/ppwm_prescaler.v
`timescale 1ns/10ps
`include "ppwm_map.vh"
module ppwm_prescaler (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Source select and sub-clock tick
   input wire [1:0] srcSel,
   input wire subTick,
   // Selected tick
   output reg tick
);
   reg [4:0] div_q;
   wire [4:0] divLast;
   ////////////////////////////////////////////////////////////////////////////
   // Free-running divider
   assign divLast = (srcSel == `PPWM_SRC_DIV8) ? `PPWM_DIV8_LAST : `PPWM_DIV32_LAST;
   always @(posedge clk) begin
      if (srst) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Source mux
   always @* begin
      case (srcSel)
         `PPWM_SRC_DIV1: tick = 1'b1;
         `PPWM_SRC_DIV8: tick = ((div_q & divLast) == divLast);
         `PPWM_SRC_DIV32: tick = ((div_q & divLast) == divLast);
         default: tick = subTick;
      endcase
   end
endmodule // ppwm_prescaler

// file: sim/ppwm_pulse_src.sv
`timescale 1ns/10ps
module ppwm_pulse_src (
   input wire clk,
   input wire run,
   input wire [15:0] hiLen,
   input wire [15:0] loLen,
   output logic pin = 1
);
   int n = 0;
   // Toggles after each phase length, idles high when stopped
   always @(posedge clk) begin
      n <= n + 1;
      if (!run || n + 1 >= (pin ? hiLen : loLen)) begin
         n <= 0;
         pin <= run ? !pin : 1'b1;
      end
   end
endmodule // ppwm_pulse_src

// file: sim/ppwm_measure_asserts.sv
`timescale 1ns/10ps
module ppwm_measure_asserts #(parameter CNT_W = 16) (
   input wire clk, srst, countStart, measMode, modeRegWrite, measurementPulsePin,
   input wire [CNT_W-1:0] timerRdData,
   input wire resultValid, overflowFlag, irqReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire pin = measurementPulsePin;
   sequence sFall; countStart && resultValid && !measMode && $fell(pin); endsequence
   sequence sBoth; countStart && resultValid && measMode && $changed(pin); endsequence
   AST_FALL: assert property (sFall |=> irqReq) else $error("no irq");
   AST_BOTH: assert property (sBoth |=> irqReq) else $error("no irq");
   AST_HOLD: assert property (!countStart || !measMode && !$fell(pin) |=>
      $stable(timerRdData)) else $error("result moved");
   AST_OVF: assert property ($rose(overflowFlag) |-> irqReq) else $error("no irq");
   AST_KEEP: assert property (overflowFlag && !(modeRegWrite && countStart) |=>
      overflowFlag) else $error("flag lost");
   AST_CLR: assert property (modeRegWrite && countStart |=>
      !overflowFlag || irqReq) else $error("flag kept");
   AST_RUN: assert property (irqReq |-> $past(countStart)) else $error("idle irq");
   AST_RV: assert property ($rose(resultValid) |-> irqReq) else $error("valid");
endmodule // ppwm_measure_asserts
bind ppwm_measure ppwm_measure_asserts #(.CNT_W(CNT_W)) u_chk (.clk(clk), .srst(srst),
   .countStart(countStart), .measMode(measMode), .modeRegWrite(modeRegWrite),
   .measurementPulsePin(measurementPulsePin), .timerRdData(timerRdData),
   .resultValid(resultValid), .overflowFlag(overflowFlag), .irqReq(irqReq));

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clk = 0, srst = 1, countStart = 0, measMode = 0, subTick = 0, modeRegWrite = 0;
   logic timerWrite = 0, run = 0, prevPin = 1, resultValid, overflowFlag, irqReq, pin;
   logic irqP = 0, datP = 0, vP = 0, tk = 0, eff = 0;
   logic [1:0] srcSel = 0;
   logic [15:0] timerWrData = 0, hiLen = 3, loLen = 3, timerRdData;
   logic [31:0] s = 67;
   int fail_count = 0, compares = 0, dv = 0, mc = 0, nEdge = 0, expD[$];
   always #20 clk = ~clk;
   function logic [31:0] rnd;
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   ppwm_measure u_dut (.clk(clk), .srst(srst), .countStart(countStart), .srcSel(srcSel),
      .measMode(measMode), .subTick(subTick), .modeRegWrite(modeRegWrite),
      .timerWrite(timerWrite), .timerWrData(timerWrData), .measurementPulsePin(pin),
      .timerRdData(timerRdData), .resultValid(resultValid), .overflowFlag(overflowFlag),
      .irqReq(irqReq));
   ppwm_pulse_src u_src (.clk(clk), .run(run), .hiLen(hiLen), .loLen(loLen), .pin(pin));
   task check(input logic [15:0] g, e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t %h %h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("%0d compares, %0d failed", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Reference model: counter, prescaler phase and edge count; answers one edge later
   always @(posedge clk) begin
      if (datP) check(timerRdData, 16'(expD.pop_front()));
      if (!srst) check(irqReq, irqP);
      if (!srst) check(resultValid, vP);
      irqP = 0;
      datP = 0;
      tk = srcSel == 0 || (srcSel == 1 && dv % 8 == 7) || (srcSel == 2 && dv % 32 == 31);
      tk = tk || (srcSel == 3 && subTick);
      dv = srst ? 0 : dv + 1;
      eff = countStart && prevPin != pin && (measMode || !pin);
      if (srst) begin
         nEdge = 0;
         mc = 0;
      end else if (!countStart) begin
         nEdge = 0;
      end else if (eff) begin
         nEdge++;
         irqP = nEdge > 1;
         datP = nEdge > 1;
         if (datP) expD.push_back(mc);
         mc = 0;
      end else if (tk) begin
         irqP = mc == 16'hFFFF;
         mc = (mc + 1) % 65536;
      end
      vP = nEdge > 1;
      prevPin = pin;
   end
   initial begin
      repeat (10) @(posedge clk);
      srst <= 0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {measMode, srcSel} <= i[2:0];
         run <= 1;
         @(posedge clk) countStart <= 1;
         repeat (300) @(posedge clk) begin
            hiLen <= 16'(1 + rnd() % 16);
            loLen <= 16'(1 + rnd() % 16);
            timerWrite <= 1'(rnd());
            timerWrData <= 16'(rnd());
            subTick <= 1'(rnd());
         end
         @(posedge clk) countStart <= 0;
         repeat (40) @(posedge clk);
         run <= 0;
      end
      {measMode, srcSel} <= 3'h0;
      @(posedge clk) countStart <= 1;
      repeat (65540) @(posedge clk);
      check(overflowFlag, 1);
      modeRegWrite <= 1;
      @(posedge clk) modeRegWrite <= 0;
      @(posedge clk) check(overflowFlag, 0);
      end_of_test;
   end
   initial begin
      repeat (75000) @(posedge clk);
      fail_count++;
      end_of_test;
   end
endmodule // testbench
